/* File: inc/bmpsr_defines.svh */
// constants for the banked register and status word unit
// assumes the including file uses the bmpsr_pkg types
`ifndef BMPSR_DEFINES_SVH
`define BMPSR_DEFINES_SVH

// mode field codes
`define BMPSR_MODE_USR    5'h10
`define BMPSR_MODE_FIQ    5'h11
`define BMPSR_MODE_IRQ    5'h12
`define BMPSR_MODE_SVC    5'h13
`define BMPSR_MODE_ABT    5'h17
`define BMPSR_MODE_UND    5'h1B

// register port addresses beyond the sixteen visible registers
`define BMPSR_ADDR_CSW    5'h10
`define BMPSR_ADDR_SSW    5'h11

// status word field positions
`define BMPSR_FLAG_HI     31
`define BMPSR_FLAG_LO     28
`define BMPSR_IRQ_DIS_BIT 7
`define BMPSR_FIQ_DIS_BIT 6
`define BMPSR_MODE_HI     4

// physical register file
`define BMPSR_NUM_GPR     31
`define BMPSR_NUM_SSW     5
`define BMPSR_PC_IDX      5'h0F
`define BMPSR_FIQ_BASE    5'h10
`define BMPSR_IRQ_BASE    5'h17
`define BMPSR_SVC_BASE    5'h19
`define BMPSR_ABT_BASE    5'h1B
`define BMPSR_UND_BASE    5'h1D

// exception vectors and link offset
`define BMPSR_VEC_RESET   32'h00000000
`define BMPSR_VEC_UND     32'h00000004
`define BMPSR_VEC_SWI     32'h00000008
`define BMPSR_VEC_PABT    32'h0000000C
`define BMPSR_VEC_DABT    32'h00000010
`define BMPSR_VEC_IRQ     32'h00000018
`define BMPSR_VEC_FIQ     32'h0000001C
`define BMPSR_LINK_ADD    32'h00000004
`define BMPSR_PC_STEP     32'h00000004

// reset values of the status word
`define BMPSR_RESET_MODE  `BMPSR_MODE_SVC
`define BMPSR_RESET_DIS   1'b1
`define BMPSR_RESET_FLAGS 4'h0

`endif

/* File: inc/bmpsr_pkg.sv */
// types for the banked register and status word unit
// assumes nothing beyond a SystemVerilog compiler
package bmpsr_pkg;

   typedef struct packed {
      logic [3:0] flags;
      logic       irq_dis;
      logic       fiq_dis;
      logic [4:0] mode;
   } bmpsr_psr_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [31:0] wdata;
   } bmpsr_bus_t;

   typedef enum logic [2:0] {
      BANK_USR, BANK_FIQ, BANK_IRQ, BANK_SVC, BANK_ABT, BANK_UND, BANK_BAD
   } bmpsr_bank_t;

   typedef enum logic [2:0] {
      EXC_NONE, EXC_UND, EXC_SWI, EXC_PABT, EXC_DABT
   } bmpsr_exc_t;

   typedef enum logic {ST_RUN, ST_LOCKED} bmpsr_state_t;

endpackage : bmpsr_pkg

/* File: rtl/bmpsr_unit.sv */
// banked general registers, current and saved status words, exception entry
// assumes a core sequencer drives the step inputs synchronously to clk
`timescale 1ns/1ps
`include "bmpsr_defines.svh"
`default_nettype none

module bmpsr_unit (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   nrst,
   // register port
   input  wire bmpsr_pkg::bmpsr_bus_t  bus,
   output var  logic [31:0]            rdata,
   // core sequencing
   input  wire logic                   instr_end,
   input  wire logic                   branch_link,
   input  wire logic [31:0]            branch_target,
   input  wire logic                   flags_we,
   input  wire logic [3:0]             flags_in,
   input  wire logic [3:0]             cond_code,
   input  wire bmpsr_pkg::bmpsr_exc_t  exc_req,
   output var  logic                   cond_pass,
   // interrupt pins
   input  wire logic                   fast_request_n,
   input  wire logic                   normal_request_n,
   input  wire logic                   sync_select,
   // state
   output var  bmpsr_pkg::bmpsr_psr_t  status,
   output var  logic [31:0]            pc,
   output var  logic                   exc_taken,
   output var  logic                   locked
);

   ////////////////////////////////////////////////////////////////////////////
   // decoding functions

   function automatic bmpsr_pkg::bmpsr_bank_t bank_of(input logic [4:0] m);
      unique case (m)
         `BMPSR_MODE_USR: bank_of = bmpsr_pkg::BANK_USR;
         `BMPSR_MODE_FIQ: bank_of = bmpsr_pkg::BANK_FIQ;
         `BMPSR_MODE_IRQ: bank_of = bmpsr_pkg::BANK_IRQ;
         `BMPSR_MODE_SVC: bank_of = bmpsr_pkg::BANK_SVC;
         `BMPSR_MODE_ABT: bank_of = bmpsr_pkg::BANK_ABT;
         `BMPSR_MODE_UND: bank_of = bmpsr_pkg::BANK_UND;
         default:         bank_of = bmpsr_pkg::BANK_BAD;
      endcase
   endfunction : bank_of

   // visible register number to physical slot
   function automatic logic [4:0] phys_idx(input logic [4:0] m, input logic [3:0] n);
      logic [4:0] base;
      base = 5'h00;
      unique case (bank_of(m))
         bmpsr_pkg::BANK_IRQ: base = `BMPSR_IRQ_BASE;
         bmpsr_pkg::BANK_SVC: base = `BMPSR_SVC_BASE;
         bmpsr_pkg::BANK_ABT: base = `BMPSR_ABT_BASE;
         bmpsr_pkg::BANK_UND: base = `BMPSR_UND_BASE;
         default:             base = 5'h00;
      endcase
      if (n == 4'hF)
         phys_idx = `BMPSR_PC_IDX;
      else if (bank_of(m) == bmpsr_pkg::BANK_FIQ && n >= 4'h8)
         phys_idx = `BMPSR_FIQ_BASE + {1'b0, n} - 5'h08;
      else if (base != 5'h00 && n >= 4'hD)
         phys_idx = base + {1'b0, n} - 5'h0D;
      else
         phys_idx = {1'b0, n};
   endfunction : phys_idx

   function automatic logic [2:0] ssw_idx(input bmpsr_pkg::bmpsr_bank_t b);
      ssw_idx = 3'(b) - 3'h1;
   endfunction : ssw_idx

   function automatic logic [31:0] pack(input bmpsr_pkg::bmpsr_psr_t p);
      pack = {p.flags, 20'h00000, p.irq_dis, p.fiq_dis, 1'b0, p.mode};
   endfunction : pack

   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v;
      {n, z, cy, v} = f;
      unique case (c)
         4'h0: cond_ok = z;
         4'h1: cond_ok = !z;
         4'h2: cond_ok = cy;
         4'h3: cond_ok = !cy;
         4'h4: cond_ok = n;
         4'h5: cond_ok = !n;
         4'h6: cond_ok = v;
         4'h7: cond_ok = !v;
         4'h8: cond_ok = cy && !z;
         4'h9: cond_ok = !cy || z;
         4'hA: cond_ok = n == v;
         4'hB: cond_ok = n != v;
         4'hC: cond_ok = !z && n == v;
         4'hD: cond_ok = z || n != v;
         4'hE: cond_ok = 1'b1;
         4'hF: cond_ok = 1'b0;
      endcase
   endfunction : cond_ok

   ////////////////////////////////////////////////////////////////////////////
   // storage

   logic [31:0]            gpr [0:`BMPSR_NUM_GPR-1];
   bmpsr_pkg::bmpsr_psr_t  ssw [0:`BMPSR_NUM_SSW-1];
   bmpsr_pkg::bmpsr_state_t state;
   logic                   fiq_s1, fiq_s2, irq_s1, irq_s2;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire bmpsr_pkg::bmpsr_bank_t cur_bank   = bank_of(status.mode);
   wire logic                   run        = state == bmpsr_pkg::ST_RUN;
   wire logic                   privileged = cur_bank != bmpsr_pkg::BANK_USR;
   wire logic                   bus_wr     = run && bus.wr;
   wire logic                   gpr_wr     = bus_wr && !bus.addr[4];
   wire logic                   csw_wr     = bus_wr && bus.addr == `BMPSR_ADDR_CSW;
   wire logic                   ssw_wr     = bus_wr && bus.addr == `BMPSR_ADDR_SSW
                                             && privileged;
   wire logic [4:0]             wr_mode    = bus.wdata[`BMPSR_MODE_HI:0];
   wire logic                   bad_mode   = csw_wr && privileged
                                             && bank_of(wr_mode) == bmpsr_pkg::BANK_BAD;

   // async requests take the second synchroniser stage, a two cycle delay
   wire logic fast_level_n   = sync_select ? fast_request_n : fiq_s2;
   wire logic normal_level_n = sync_select ? normal_request_n : irq_s2;

   // interrupts are looked at only when an instruction ends
   wire logic fiq_go  = run && instr_end && !fast_level_n && !status.fiq_dis;
   wire logic irq_go  = run && instr_end && !normal_level_n && !status.irq_dis;
   wire logic dabt_go = run && instr_end && exc_req == bmpsr_pkg::EXC_DABT;
   wire logic pabt_go = run && instr_end && exc_req == bmpsr_pkg::EXC_PABT;
   wire logic und_go  = run && instr_end && exc_req == bmpsr_pkg::EXC_UND;
   wire logic swi_go  = run && instr_end && exc_req == bmpsr_pkg::EXC_SWI;
   wire logic take    = dabt_go || fiq_go || irq_go || pabt_go || und_go || swi_go;

   // fixed priority: data abort, fast, normal, prefetch abort, undefined or swi
   wire logic [4:0] entry_mode =
      dabt_go ? `BMPSR_MODE_ABT :
      fiq_go  ? `BMPSR_MODE_FIQ :
      irq_go  ? `BMPSR_MODE_IRQ :
      pabt_go ? `BMPSR_MODE_ABT :
      und_go  ? `BMPSR_MODE_UND : `BMPSR_MODE_SVC;
   wire logic [31:0] entry_vec =
      dabt_go ? `BMPSR_VEC_DABT :
      fiq_go  ? `BMPSR_VEC_FIQ :
      irq_go  ? `BMPSR_VEC_IRQ :
      pabt_go ? `BMPSR_VEC_PABT :
      und_go  ? `BMPSR_VEC_UND : `BMPSR_VEC_SWI;
   // pc already holds the next instruction address when the instruction ends
   wire logic [31:0] entry_link = (dabt_go || fiq_go || irq_go)
                                  ? gpr[`BMPSR_PC_IDX] + `BMPSR_LINK_ADD
                                  : gpr[`BMPSR_PC_IDX];
   wire logic        entry_fiq_dis = fiq_go && !dabt_go;
   wire logic [2:0]  entry_ssw     = ssw_idx(bank_of(entry_mode));
   wire logic [4:0]  entry_lr      = phys_idx(entry_mode, 4'hE);
   wire logic [4:0]  cur_lr        = phys_idx(status.mode, 4'hE);
   wire logic [4:0]  wr_idx        = phys_idx(status.mode, bus.addr[3:0]);
   wire logic [31:0] link_cur      = gpr[cur_lr];

   // read selection
   wire logic [31:0] gpr_rd = gpr[phys_idx(status.mode, bus.addr[3:0])];
   wire logic [31:0] ssw_rd = privileged ? pack(ssw[ssw_idx(cur_bank)]) : 32'h00000000;
   wire logic [31:0] rd_mux =
      !bus.addr[4]                   ? gpr_rd :
      bus.addr == `BMPSR_ADDR_CSW    ? pack(status) :
      bus.addr == `BMPSR_ADDR_SSW    ? ssw_rd : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {fiq_s1, fiq_s2, irq_s1, irq_s2} <= 4'hF;
      end else begin
         {fiq_s2, fiq_s1} <= {fiq_s1, fast_request_n};
         {irq_s2, irq_s1} <= {irq_s1, normal_request_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // general registers; later assignments take priority

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `BMPSR_NUM_GPR; i++) begin
            gpr[i] <= 32'h00000000;
         end
         gpr[`BMPSR_PC_IDX] <= `BMPSR_VEC_RESET;
      end else begin
         if (gpr_wr)
            gpr[wr_idx] <= (wr_idx == `BMPSR_PC_IDX) ? {bus.wdata[31:2], 2'h0} : bus.wdata;
         if (run && instr_end)
            gpr[`BMPSR_PC_IDX] <= gpr[`BMPSR_PC_IDX] + `BMPSR_PC_STEP;
         if (run && branch_link) begin
            gpr[cur_lr]        <= gpr[`BMPSR_PC_IDX];
            gpr[`BMPSR_PC_IDX] <= {branch_target[31:2], 2'h0};
         end
         if (take) begin
            gpr[entry_lr]      <= entry_link;
            gpr[`BMPSR_PC_IDX] <= entry_vec;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status words

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status <= '{`BMPSR_RESET_FLAGS, `BMPSR_RESET_DIS, `BMPSR_RESET_DIS,
                     `BMPSR_RESET_MODE};
         for (int i = 0; i < `BMPSR_NUM_SSW; i++) begin
            ssw[i] <= '{4'h0, 1'b0, 1'b0, 5'h00};
         end
      end else begin
         if (csw_wr) begin
            status.flags <= bus.wdata[`BMPSR_FLAG_HI:`BMPSR_FLAG_LO];
            if (privileged) begin
               status.irq_dis <= bus.wdata[`BMPSR_IRQ_DIS_BIT];
               status.fiq_dis <= bus.wdata[`BMPSR_FIQ_DIS_BIT];
               status.mode    <= wr_mode;
            end
         end
         if (ssw_wr)
            ssw[ssw_idx(cur_bank)] <= '{bus.wdata[`BMPSR_FLAG_HI:`BMPSR_FLAG_LO],
                                        bus.wdata[`BMPSR_IRQ_DIS_BIT],
                                        bus.wdata[`BMPSR_FIQ_DIS_BIT], wr_mode};
         if (run && flags_we)
            status.flags <= flags_in;
         if (take) begin
            ssw[entry_ssw] <= status;
            status.mode    <= entry_mode;
            status.irq_dis <= 1'b1;
            if (entry_fiq_dis)
               status.fiq_dis <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock state, answers and flags

   // a bad mode has no bank behind it, so the unit refuses all writes, steps and exceptions until reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= bmpsr_pkg::ST_RUN;
      end else begin
         unique case (state)
            bmpsr_pkg::ST_RUN:    if (bad_mode) state <= bmpsr_pkg::ST_LOCKED;
            bmpsr_pkg::ST_LOCKED: state <= bmpsr_pkg::ST_LOCKED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata     <= 32'h00000000;
         cond_pass <= 1'b0;
         exc_taken <= 1'b0;
         locked    <= 1'b0;
         pc        <= `BMPSR_VEC_RESET;
      end else begin
         rdata     <= bus.rd ? rd_mux : 32'h00000000;
         cond_pass <= cond_ok(cond_code, status.flags);
         exc_taken <= take;
         locked    <= state == bmpsr_pkg::ST_LOCKED || bad_mode;
         pc        <= take ? entry_vec : gpr[`BMPSR_PC_IDX];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   pc_read_a: assert property (bus.rd && bus.addr == 5'h0F |=>
      rdata[1:0] == 2'h0 && rdata[31:2] == $past(gpr[`BMPSR_PC_IDX][31:2]))
      else $error("pc read not word aligned");

   branch_link_a: assert property (run && branch_link && !take && !csw_wr |=>
      link_cur == $past(gpr[`BMPSR_PC_IDX]))
      else $error("link register missed the pc copy");

   fast_entry_a: assert property (fiq_go && !dabt_go |=>
      status.mode == `BMPSR_MODE_FIQ && status.fiq_dis && status.irq_dis
      && gpr[`BMPSR_PC_IDX] == `BMPSR_VEC_FIQ && exc_taken)
      else $error("fast entry state wrong");

   normal_entry_a: assert property (irq_go && !fiq_go && !dabt_go |=>
      status.mode == `BMPSR_MODE_IRQ && status.irq_dis
      && gpr[`BMPSR_PC_IDX] == `BMPSR_VEC_IRQ)
      else $error("normal entry state wrong");

   saved_word_a: assert property (take |=>
      ssw[$past(entry_ssw)] == $past(status))
      else $error("saved status not loaded on entry");

   masked_irq_a: assert property (instr_end && status.fiq_dis && status.irq_dis
      && exc_req == bmpsr_pkg::EXC_NONE |=> !exc_taken)
      else $error("masked interrupt was taken");

   user_ctrl_a: assert property (csw_wr && !privileged && !take |=>
      status.irq_dis == $past(status.irq_dis) && status.fiq_dis == $past(status.fiq_dis)
      && status.mode == $past(status.mode))
      else $error("user write changed control bits");

   sync_delay_a: assert property (!sync_select && $past(!sync_select) |->
      fast_level_n == $past(fast_request_n, 2))
      else $error("synchroniser delay wrong");

   lock_hold_a: assert property (bad_mode |=> locked ##1 locked && !exc_taken)
      else $error("illegal mode did not lock");

   flags_upd_a: assert property (run && flags_we && !take |=>
      status.flags == $past(flags_in))
      else $error("flags not updated");

   reserved_zero_a: assert property (bus.rd && bus.addr == `BMPSR_ADDR_CSW |=>
      rdata[27:8] == 20'h00000 && !rdata[5])
      else $error("reserved status bits not zero");

   read_idle_a: assert property (!bus.rd |=> rdata == 32'h00000000)
      else $error("read data outside its cycle");

   lock_freeze_a: assert property (state == bmpsr_pkg::ST_LOCKED |=>
      status == $past(status) && !exc_taken)
      else $error("locked unit changed state");

   entry_vec_a: assert property (take |=> exc_taken && pc == $past(entry_vec))
      else $error("entry vector not shown");

   mode_write_a: assert property (csw_wr && privileged && !take |=>
      status.mode == $past(wr_mode))
      else $error("privileged mode write lost");

   data_abort_a: assert property (dabt_go |=>
      status.mode == `BMPSR_MODE_ABT && gpr[`BMPSR_PC_IDX] == `BMPSR_VEC_DABT)
      else $error("data abort entry wrong");

   pc_step_a: assert property (run && instr_end && !take && !branch_link |=>
      gpr[`BMPSR_PC_IDX] == $past(gpr[`BMPSR_PC_IDX]) + `BMPSR_PC_STEP)
      else $error("pc did not step");

   ssw_user_a: assert property (bus.rd && bus.addr == `BMPSR_ADDR_SSW && !privileged |=>
      rdata == 32'h00000000)
      else $error("user read of saved word not zero");

endmodule : bmpsr_unit

`default_nettype wire

/* File: tb/bmpsr_irq_src.sv */
// model of the peripherals that raise the two interrupt request lines
// assumes the bench holds want_* high until the unit has taken the interrupt
`timescale 1ns/1ps
`default_nettype none

module bmpsr_irq_src (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // bench commands
   input  wire logic       want_fast,
   input  wire logic       want_normal,
   input  wire logic [3:0] lag,
   // request lines, pulled up, so idle high
   output var  logic       fast_request_n,
   output var  logic       normal_request_n
);
   ////////////////////////////////////////
   logic [3:0] cnt;
   logic       due;

   // lag lets a slow source hold off its request for a few cycles
   assign due = (cnt == lag);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt              <= 4'h0;
         fast_request_n   <= 1'b1;
         normal_request_n <= 1'b1;
      end else begin
         cnt              <= !(want_fast || want_normal) ? 4'h0 : (due ? cnt : cnt + 4'h1);
         fast_request_n   <= !(want_fast && due);
         normal_request_n <= !(want_normal && due);
      end
   end
endmodule : bmpsr_irq_src
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the banked register and status word unit
// assumes bmpsr_pkg is compiled first and the request model sits beside it
`timescale 1ns/1ps
`default_nettype none

module tb;
   ////////////////////////////////////////
   logic                  clk;
   logic                  nrst;
   bmpsr_pkg::bmpsr_bus_t bus;
   logic [31:0]           rdata;
   logic                  instr_end;
   logic                  branch_link;
   logic [31:0]           branch_target;
   logic                  flags_we;
   logic [3:0]            flags_in;
   logic [3:0]            cond_code;
   bmpsr_pkg::bmpsr_exc_t exc_req;
   logic                  cond_pass;
   logic                  fast_request_n;
   logic                  normal_request_n;
   logic                  sync_select;
   bmpsr_pkg::bmpsr_psr_t status;
   logic [31:0]           pc;
   logic                  exc_taken;
   logic                  locked;
   logic                  want_fast;
   logic                  want_normal;
   logic [3:0]            lag;
   logic [31:0]           epc;
   int                    fail_count;
   int                    comparisons;
   int                    cycles;
   bmpsr_pkg::bmpsr_exc_t ex [4] = '{bmpsr_pkg::EXC_UND, bmpsr_pkg::EXC_SWI,
                                     bmpsr_pkg::EXC_PABT, bmpsr_pkg::EXC_DABT};
   logic [4:0]            md [4] = '{5'h1B, 5'h13, 5'h17, 5'h17};
   logic [31:0]           vec [4] = '{32'h04, 32'h08, 32'h0C, 32'h10};
   logic [31:0]           lk [4] = '{32'h0, 32'h0, 32'h0, 32'h4};
   logic [15:0]           cond_exp = 16'h56AA;

   bmpsr_unit uut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
      .instr_end(instr_end), .branch_link(branch_link), .branch_target(branch_target),
      .flags_we(flags_we), .flags_in(flags_in), .cond_code(cond_code), .exc_req(exc_req),
      .cond_pass(cond_pass), .fast_request_n(fast_request_n),
      .normal_request_n(normal_request_n), .sync_select(sync_select), .status(status),
      .pc(pc), .exc_taken(exc_taken), .locked(locked));

   bmpsr_irq_src src (.clk(clk), .nrst(nrst), .want_fast(want_fast),
      .want_normal(want_normal), .lag(lag), .fast_request_n(fast_request_n),
      .normal_request_n(normal_request_n));

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd

   task automatic step(input bmpsr_pkg::bmpsr_exc_t e, input logic taken);
      @(posedge clk);
      instr_end <= 1'b1;
      exc_req   <= e;
      @(posedge clk);
      instr_end <= 1'b0;
      exc_req   <= bmpsr_pkg::EXC_NONE;
      #1;
      chk(32'(exc_taken), 32'(taken));
   endtask : step

   task automatic entered(input logic [4:0] m, input logic [31:0] v, input logic [31:0] l);
      chk(32'(status.mode), 32'(m));
      @(posedge clk);
      #1;
      chk(pc, v);
      rd(5'h0E, l);
      epc = v;
   endtask : entered

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      {nrst, instr_end, branch_link, flags_we, want_fast, want_normal} = '0;
      bus = '0;
      branch_target = 32'h0;
      flags_in = 4'h0;
      cond_code = 4'h0;
      exc_req = bmpsr_pkg::EXC_NONE;
      sync_select = 1'b1;
      lag = 4'h0;
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(5'h10, 32'h000000D3);
      rd(5'h0F, 32'h00000000);
      $display("test reset done");
      wr(5'h07, 32'h77777777);
      wr(5'h08, 32'h11111111);
      wr(5'h0D, 32'h22222222);
      wr(5'h0E, 32'h33333333);
      wr(5'h10, 32'h000000D1);
      rd(5'h08, 32'h00000000);
      rd(5'h07, 32'h77777777);
      wr(5'h08, 32'h88888888);
      wr(5'h10, 32'h000000D2);
      rd(5'h08, 32'h11111111);
      rd(5'h0D, 32'h00000000);
      wr(5'h10, 32'h000000D3);
      rd(5'h0D, 32'h22222222);
      rd(5'h0E, 32'h33333333);
      rd(5'h12, 32'h00000000);
      $display("test banking done");
      wr(5'h0F, 32'h00000103);
      rd(5'h0F, 32'h00000100);
      epc = 32'h100;
      wr(5'h10, 32'hF0000FD3);
      rd(5'h10, 32'hF00000D3);
      wr(5'h10, 32'h00000010);
      wr(5'h10, 32'h400000D3);
      rd(5'h10, 32'h40000010);
      rd(5'h11, 32'h00000000);
      chk(32'(cond_pass), 32'h1);
      @(posedge clk);
      flags_we <= 1'b1;
      @(posedge clk);
      flags_we <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(32'(cond_pass), 32'h0);
      for (int c = 0; c < 16; c++) begin
         cond_code <= 4'(c);
         repeat (2) @(posedge clk);
         #1;
         chk(32'(cond_pass), 32'(cond_exp[c]));
      end
      $display("test user mode done");
      lag <= 4'h3;
      want_fast <= 1'b1;
      repeat (6) @(posedge clk);
      step(bmpsr_pkg::EXC_NONE, 1'b1);
      chk(32'(status), 32'h00000071);
      entered(5'h11, 32'h0000001C, epc + 32'h4);
      rd(5'h11, 32'h00000010);
      step(bmpsr_pkg::EXC_NONE, 1'b0);
      want_fast <= 1'b0;
      rd(5'h0F, 32'h00000020);
      @(posedge clk);
      branch_link   <= 1'b1;
      branch_target <= 32'h00000203;
      @(posedge clk);
      branch_link <= 1'b0;
      rd(5'h0E, 32'h00000020);
      rd(5'h0F, 32'h00000200);
      $display("test fast interrupt done");
      wr(5'h10, 32'h00000053);
      sync_select <= 1'b0;
      lag <= 4'h0;
      @(posedge clk);
      want_normal <= 1'b1;
      step(bmpsr_pkg::EXC_NONE, 1'b0);
      repeat (2) @(posedge clk);
      step(bmpsr_pkg::EXC_NONE, 1'b1);
      chk(32'(status), 32'h00000072);
      entered(5'h12, 32'h00000018, 32'h00000208);
      rd(5'h11, 32'h00000053);
      for (int k = 0; k < 4; k++) begin
         step(ex[k], 1'b1);
         entered(md[k], vec[k], epc + lk[k]);
      end
      want_normal <= 1'b0;
      $display("test exceptions done");
      wr(5'h10, 32'h000000D5);
      @(posedge clk);
      #1;
      chk(32'(locked), 32'h1);
      wr(5'h00, 32'h5A5A5A5A);
      rd(5'h00, 32'h00000000);
      $display("test illegal mode done");
      end_of_test();
   end
endmodule : tb
`default_nettype wire
